/* rtl/dpv_pkg.sv */
// Package: constants, register layouts and types for DAC playback control
//
// Behaviour
// - boost_level picks off, min, mid, max boost.
// - Boosted sample saturates at full scale, never wraps.
// - 8-bit code, 0.5dB per step, FFH mutes.
// - volume_link set: left code drives both channels.
// - volume_link clear: each channel uses own code.
// - Attenuation glides; full sweep takes 1061 samples.
// - soft_mute_req set ramps output down to zero.
// - soft_mute_req cleared ramps output back to 0dB.
// - Early cancel reverses ramp from current point.
// - Mute gain multiplies after channel attenuator gain.
// - Stereo beep powered, optionally mixed into phones.
// - Stereo beep average feeds the speaker path.
// - Mono beep: phones at -20dB, speaker unity.
// - Bias bits clear force phones low, set raise.
// - Amp-off bits power amp down, outputs low.
package dpv_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_VOL = 8'h04;
  localparam logic [7:0] ADDR_BEEP = 8'h08;
  localparam logic [7:0] ADDR_PHONE = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  typedef struct packed {
    logic [1:0] mute_ramp_period;
    logic soft_mute_req;
    logic volume_link;
    logic [1:0] boost_level;
  } dpv_ctrl_t;

  typedef struct packed {
    logic [7:0] right_volume_code;
    logic [7:0] left_volume_code;
  } dpv_vol_t;

  typedef struct packed {
    logic mono_beep_to_speaker;
    logic mono_beep_to_phones;
    logic mono_beep_power;
    logic stereo_beep_to_speaker;
    logic stereo_beep_to_phones;
    logic stereo_beep_power;
  } dpv_beep_t;

  typedef struct packed {
    logic right_phone_amp_off;
    logic left_phone_amp_off;
    logic right_phone_bias_on;
    logic left_phone_bias_on;
  } dpv_phone_t;

  typedef struct packed {
    logic mute_busy;
    logic [7:0] cur_right;
    logic [7:0] cur_left;
  } dpv_status_t;

  typedef struct packed {
    dpv_ctrl_t ctrl;
    dpv_vol_t vol;
    dpv_beep_t beep;
    dpv_phone_t phone;
  } dpv_cfg_t;

  localparam dpv_ctrl_t CTRL_RST = 6'h00;
  localparam dpv_vol_t VOL_RST = 16'h0000;
  localparam dpv_beep_t BEEP_RST = 6'h00;
  localparam dpv_phone_t PHONE_RST = 4'hC;

  // ****************************************************************
  // Data path constants
  // ****************************************************************
  localparam logic [1:0] BOOST_OFF = 2'h0;
  localparam logic [1:0] BOOST_MIN = 2'h1;
  localparam logic [1:0] BOOST_MID = 2'h2;
  localparam logic [1:0] BOOST_MAX = 2'h3;
  localparam int BOOST_LP_SHIFT = 4;
  localparam int BOOST_MIN_SHIFT = 2;
  localparam int BOOST_MID_SHIFT = 1;

  localparam logic signed [17:0] SMP_MAX = 18'h0_7FFF;
  localparam logic signed [17:0] SMP_MIN = -18'sh0_8000;
  localparam logic [7:0] ATT_MUTE = 8'hFF;
  localparam logic [7:0] ATT_PER_OCT = 8'h0C;
  localparam logic [11:0] SWEEP_STEPS = 12'h0FF;
  localparam logic [11:0] SWEEP_SAMPLES = 12'h425;

  localparam logic [15:0] MUTE_FULL = 16'h8000;
  localparam int MUTE_LEN [4] = '{256, 512, 1024, 2048};

  localparam logic signed [15:0] BEEP_AMP = 16'h2000;
  localparam logic signed [15:0] MONO_PHONE_AMP = 16'h0333;

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } dpv_stereo_t;

  typedef struct packed {
    logic signed [15:0] lp;
    logic [7:0] code;
    logic [10:0] acc;
    logic signed [15:0] out;
  } dpv_chan_st_t;

  typedef struct packed {
    dpv_cfg_t cfg;
    logic [15:0] mute_gain;
    logic [31:0] rdata;
    logic err;
    logic [2:0] tone_meta;
    logic [2:0] tone_sync;
    logic stb_d;
    logic out_valid;
    dpv_stereo_t out;
    logic signed [15:0] spk;
  } dpv_top_st_t;

  // Mantissa of 0.5dB steps within one 6dB octave, Q15
  function automatic logic [15:0] att_gain(input logic [7:0] code);
    logic [15:0] mant;
    logic [7:0] oct;
    oct = code / ATT_PER_OCT;
    unique case (code % ATT_PER_OCT)
      8'h00: mant = 16'h8000;
      8'h01: mant = 16'h78D7;
      8'h02: mant = 16'h7215;
      8'h03: mant = 16'h6BB3;
      8'h04: mant = 16'h65AD;
      8'h05: mant = 16'h5FFD;
      8'h06: mant = 16'h5A9E;
      8'h07: mant = 16'h558C;
      8'h08: mant = 16'h50C3;
      8'h09: mant = 16'h4C3F;
      8'h0A: mant = 16'h47FB;
      default: mant = 16'h43F4;
    endcase
    att_gain = (code == ATT_MUTE) ? 16'h0000 : (mant >> oct);
  endfunction : att_gain

  function automatic logic [15:0] mute_step(input logic [1:0] sel);
    mute_step = 16'(int'(MUTE_FULL) / MUTE_LEN[sel]);
  endfunction : mute_step

  function automatic logic signed [15:0] sat16(
    input logic signed [17:0] v
  );
    if (v > SMP_MAX) begin
      sat16 = SMP_MAX[15:0];
    end else if (v < SMP_MIN) begin
      sat16 = SMP_MIN[15:0];
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

endpackage : dpv_pkg

/* rtl/dpv_chan.sv */
// One channel: bass boost, clipping, gliding attenuator, mute cascade
`timescale 1ns/1ps
`default_nettype none
module dpv_chan (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Sync reset, active high
  input wire logic smp_stb, // One cycle per sample
  input wire logic signed [15:0] smp_in, // Incoming sample
  input wire logic [1:0] boost_level, // Boost select
  input wire logic [7:0] target_code, // Requested attenuation
  input wire logic [15:0] mute_gain, // Soft mute gain, Q15
  output logic signed [15:0] smp_out, // Processed sample
  output logic [7:0] cur_code // Attenuation now applied
);
  dpv_pkg::dpv_chan_st_t st_r, st_nxt;
  logic signed [17:0] x_ext, lp_ext, diff, boost, sum;
  logic signed [15:0] clip, atten;
  logic signed [32:0] prod_a, prod_b;
  logic [11:0] acc_sum;

  always_comb begin
    st_nxt = st_r;
    x_ext = {{2{smp_in[15]}}, smp_in};
    lp_ext = {{2{st_r.lp[15]}}, st_r.lp};
    diff = x_ext - lp_ext;
    unique case (boost_level)
      dpv_pkg::BOOST_OFF: boost = '0;
      dpv_pkg::BOOST_MIN: boost = lp_ext >>> dpv_pkg::BOOST_MIN_SHIFT;
      dpv_pkg::BOOST_MID: boost = lp_ext >>> dpv_pkg::BOOST_MID_SHIFT;
      dpv_pkg::BOOST_MAX: boost = lp_ext;
    endcase
    sum = x_ext + boost;
    clip = dpv_pkg::sat16(sum);
    prod_a = clip * $signed({1'b0, dpv_pkg::att_gain(st_r.code)});
    atten = prod_a[30:15];
    prod_b = atten * $signed({1'b0, mute_gain});
    acc_sum = {1'b0, st_r.acc} + dpv_pkg::SWEEP_STEPS;
    if (smp_stb) begin
      st_nxt.lp = st_r.lp + 16'(diff >>> dpv_pkg::BOOST_LP_SHIFT);
      st_nxt.out = prod_b[30:15];
      if (st_r.code == target_code) begin
        st_nxt.acc = '0;
      end else if (acc_sum >= dpv_pkg::SWEEP_SAMPLES) begin
        st_nxt.acc = 11'(acc_sum - dpv_pkg::SWEEP_SAMPLES);
        st_nxt.code = (st_r.code < target_code) ? st_r.code + 8'h01
                                                : st_r.code - 8'h01;
      end else begin
        st_nxt.acc = acc_sum[10:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign smp_out = st_r.out;
  assign cur_code = st_r.code;

  a_clip_no_wrap: assert property (@(posedge ref_clk) disable iff (rst)
    (smp_stb && !smp_in[15] && !boost[17]) |=> !smp_out[15])
    else $error("boosted positive sample wrapped negative");
  a_mute_code_zero: assert property (@(posedge ref_clk)
    disable iff (rst)
    (smp_stb && st_r.code == dpv_pkg::ATT_MUTE) |=> smp_out == '0)
    else $error("mute code passed signal");
  a_sweep_one_step: assert property (@(posedge ref_clk)
    disable iff (rst)
    smp_stb |=> (cur_code == $past(cur_code) ||
                 cur_code == $past(cur_code) + 8'h01 ||
                 cur_code == $past(cur_code) - 8'h01))
    else $error("attenuator moved more than one step");
  a_sweep_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !smp_stb |=> $stable(cur_code))
    else $error("attenuator moved without a sample");
endmodule : dpv_chan
`default_nettype wire

/* rtl/dpv_top.sv */
// Top: APB registers, soft mute, beep mixing, headphone control
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dpv_top (
  input wire logic ref_clk, // Core clock, 40 MHz
  input wire logic rst, // Sync reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic sample_valid, // One cycle per sample period
  input wire dpv_pkg::dpv_stereo_t sample_in, // Host samples
  output logic out_valid, // Output sample strobe
  output dpv_pkg::dpv_stereo_t sample_out, // Headphone samples
  output logic signed [15:0] speaker_sample, // Speaker path sample
  input wire logic left_tone_input, // Left beep pin
  input wire logic right_tone_input, // Right beep pin
  input wire logic mono_tone_input, // Mono beep pin
  output logic stereo_beep_power, // Stereo beep input power
  output logic mono_beep_power, // Mono beep input power
  output logic left_phone_bias_on, // Left common level up
  output logic right_phone_bias_on, // Right common level up
  output logic left_phone_amp_en, // Left amp powered
  output logic right_phone_amp_en, // Right amp powered
  output logic left_phone_drive_low, // Left output held low
  output logic right_phone_drive_low // Right output held low
);

  // ****************************************************************
  // State and wires
  // ****************************************************************
  dpv_pkg::dpv_top_st_t st_r, st_nxt;
  dpv_pkg::dpv_stereo_t chan_out;
  logic [7:0] left_target;
  logic [7:0] right_target;
  logic [7:0] cur_left;
  logic [7:0] cur_right;
  logic [15:0] step;
  logic [16:0] gain_up;
  logic mute_busy;
  logic setup;
  logic wr_acc;
  logic signed [15:0] beep_l;
  logic signed [15:0] beep_r;
  logic signed [15:0] beep_m;
  logic signed [17:0] mix_l;
  logic signed [17:0] mix_r;
  logic signed [17:0] mix_s;
  dpv_pkg::dpv_status_t status;

  // ****************************************************************
  // Volume targets
  // ****************************************************************
  always_comb begin
    left_target = st_r.cfg.vol.left_volume_code;
    if (st_r.cfg.ctrl.volume_link) begin
      right_target = st_r.cfg.vol.left_volume_code;
    end else begin
      right_target = st_r.cfg.vol.right_volume_code;
    end
  end

  // ****************************************************************
  // Channel data paths
  // ****************************************************************
  dpv_chan u_left (
    .ref_clk(ref_clk),
    .rst(rst),
    .smp_stb(sample_valid),
    .smp_in(sample_in.left),
    .boost_level(st_r.cfg.ctrl.boost_level),
    .target_code(left_target),
    .mute_gain(st_r.mute_gain),
    .smp_out(chan_out.left),
    .cur_code(cur_left)
  );

  dpv_chan u_right (
    .ref_clk(ref_clk),
    .rst(rst),
    .smp_stb(sample_valid),
    .smp_in(sample_in.right),
    .boost_level(st_r.cfg.ctrl.boost_level),
    .target_code(right_target),
    .mute_gain(st_r.mute_gain),
    .smp_out(chan_out.right),
    .cur_code(cur_right)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_nxt = st_r;
    setup = psel && !penable;
    wr_acc = psel && penable && pwrite;
    step = dpv_pkg::mute_step(st_r.cfg.ctrl.mute_ramp_period);
    gain_up = {1'b0, st_r.mute_gain} + {1'b0, step};
    mute_busy = st_r.cfg.ctrl.soft_mute_req ? (st_r.mute_gain != '0)
                : (st_r.mute_gain != dpv_pkg::MUTE_FULL);
    status = '{mute_busy: mute_busy, cur_right: cur_right,
               cur_left: cur_left};

    // Register reads captured in the setup phase
    if (setup) begin
      st_nxt.err = 1'b0;
      st_nxt.rdata = '0;
      unique case (paddr)
        dpv_pkg::ADDR_CTRL: st_nxt.rdata = 32'(st_r.cfg.ctrl);
        dpv_pkg::ADDR_VOL: st_nxt.rdata = 32'(st_r.cfg.vol);
        dpv_pkg::ADDR_BEEP: st_nxt.rdata = 32'(st_r.cfg.beep);
        dpv_pkg::ADDR_PHONE: st_nxt.rdata = 32'(st_r.cfg.phone);
        dpv_pkg::ADDR_STATUS: st_nxt.rdata = 32'(status);
        default: st_nxt.err = 1'b1;
      endcase
    end

    // Register writes at the access edge
    if (wr_acc) begin
      unique case (paddr)
        dpv_pkg::ADDR_CTRL: begin
          st_nxt.cfg.ctrl = pwdata[$bits(dpv_pkg::dpv_ctrl_t)-1:0];
        end
        dpv_pkg::ADDR_VOL: begin
          st_nxt.cfg.vol = pwdata[$bits(dpv_pkg::dpv_vol_t)-1:0];
        end
        dpv_pkg::ADDR_BEEP: begin
          st_nxt.cfg.beep = pwdata[$bits(dpv_pkg::dpv_beep_t)-1:0];
        end
        dpv_pkg::ADDR_PHONE: begin
          st_nxt.cfg.phone = pwdata[$bits(dpv_pkg::dpv_phone_t)-1:0];
        end
        default: begin
          st_nxt.cfg = st_r.cfg;
        end
      endcase
    end

    // Soft mute ramp, one equal step per sample
    if (sample_valid) begin
      if (st_r.cfg.ctrl.soft_mute_req) begin
        if (st_r.mute_gain > step) begin
          st_nxt.mute_gain = st_r.mute_gain - step;
        end else begin
          st_nxt.mute_gain = '0;
        end
      end else if (gain_up >= {1'b0, dpv_pkg::MUTE_FULL}) begin
        st_nxt.mute_gain = dpv_pkg::MUTE_FULL;
      end else begin
        st_nxt.mute_gain = gain_up[15:0];
      end
    end

    // Beep pins pass two flops before use
    st_nxt.tone_meta = {mono_tone_input, right_tone_input,
                        left_tone_input};
    st_nxt.tone_sync = st_r.tone_meta;
    beep_l = st_r.tone_sync[0] ? dpv_pkg::BEEP_AMP : -dpv_pkg::BEEP_AMP;
    beep_r = st_r.tone_sync[1] ? dpv_pkg::BEEP_AMP : -dpv_pkg::BEEP_AMP;
    beep_m = st_r.tone_sync[2] ? dpv_pkg::BEEP_AMP : -dpv_pkg::BEEP_AMP;

    // Headphone mix
    mix_l = 18'(chan_out.left);
    mix_r = 18'(chan_out.right);
    if (st_r.cfg.beep.stereo_beep_power &&
        st_r.cfg.beep.stereo_beep_to_phones) begin
      mix_l = mix_l + 18'(beep_l);
      mix_r = mix_r + 18'(beep_r);
    end
    if (st_r.cfg.beep.mono_beep_power &&
        st_r.cfg.beep.mono_beep_to_phones) begin
      mix_l = st_r.tone_sync[2] ? mix_l + 18'(dpv_pkg::MONO_PHONE_AMP)
                                : mix_l - 18'(dpv_pkg::MONO_PHONE_AMP);
      mix_r = st_r.tone_sync[2] ? mix_r + 18'(dpv_pkg::MONO_PHONE_AMP)
                                : mix_r - 18'(dpv_pkg::MONO_PHONE_AMP);
    end

    // Speaker mix
    mix_s = '0;
    if (st_r.cfg.beep.stereo_beep_power &&
        st_r.cfg.beep.stereo_beep_to_speaker) begin
      mix_s = (18'(beep_l) + 18'(beep_r)) >>> 1;
    end
    if (st_r.cfg.beep.mono_beep_power &&
        st_r.cfg.beep.mono_beep_to_speaker) begin
      mix_s = mix_s + 18'(beep_m);
    end
    st_nxt.spk = dpv_pkg::sat16(mix_s);

    // Output stage, one cycle after the channel registers
    st_nxt.stb_d = sample_valid;
    st_nxt.out_valid = st_r.stb_d;
    if (st_r.stb_d) begin
      st_nxt.out.left = left_phone_drive_low ? '0
                        : dpv_pkg::sat16(mix_l);
      st_nxt.out.right = right_phone_drive_low ? '0
                         : dpv_pkg::sat16(mix_r);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.cfg <= '{ctrl: dpv_pkg::CTRL_RST, vol: dpv_pkg::VOL_RST,
                    beep: dpv_pkg::BEEP_RST, phone: dpv_pkg::PHONE_RST};
      st_r.mute_gain <= dpv_pkg::MUTE_FULL;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = st_r.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && st_r.err;
  assign out_valid = st_r.out_valid;
  assign sample_out = st_r.out;
  assign speaker_sample = st_r.spk;
  assign stereo_beep_power = st_r.cfg.beep.stereo_beep_power;
  assign mono_beep_power = st_r.cfg.beep.mono_beep_power;
  assign left_phone_bias_on = st_r.cfg.phone.left_phone_bias_on;
  assign right_phone_bias_on = st_r.cfg.phone.right_phone_bias_on;
  assign left_phone_amp_en = !st_r.cfg.phone.left_phone_amp_off;
  assign right_phone_amp_en = !st_r.cfg.phone.right_phone_amp_off;
  assign left_phone_drive_low = st_r.cfg.phone.left_phone_amp_off ||
                                !st_r.cfg.phone.left_phone_bias_on;
  assign right_phone_drive_low = st_r.cfg.phone.right_phone_amp_off ||
                                 !st_r.cfg.phone.right_phone_bias_on;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_boost_reset_off: assert property (@(posedge ref_clk)
    $past(rst) && !rst |-> st_r.cfg.ctrl.boost_level == dpv_pkg::BOOST_OFF)
    else $error("boost not off after reset");
  a_link_right_code: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.cfg.ctrl.volume_link |-> right_target == left_target)
    else $error("linked right channel not following left code");
  a_unlinked_right: assert property (@(posedge ref_clk) disable iff (rst)
    !st_r.cfg.ctrl.volume_link
    |-> right_target == st_r.cfg.vol.right_volume_code)
    else $error("unlinked right channel not using right code");
  a_mute_ramp_down: assert property (@(posedge ref_clk) disable iff (rst)
    (sample_valid && st_r.cfg.ctrl.soft_mute_req && st_r.mute_gain != '0 &&
     !wr_acc) |=> st_r.mute_gain < $past(st_r.mute_gain))
    else $error("mute gain did not fall");
  a_mute_ramp_up: assert property (@(posedge ref_clk) disable iff (rst)
    (sample_valid && !st_r.cfg.ctrl.soft_mute_req && !wr_acc &&
     st_r.mute_gain != dpv_pkg::MUTE_FULL)
    |=> st_r.mute_gain > $past(st_r.mute_gain))
    else $error("mute gain did not rise after cancel");
  a_mute_equal_step: assert property (@(posedge ref_clk) disable iff (rst)
    (sample_valid && !wr_acc && st_r.cfg.ctrl.soft_mute_req &&
     st_r.mute_gain > step)
    |=> $past(st_r.mute_gain) - st_r.mute_gain == $past(step))
    else $error("mute step not equal to table step");
  a_mute_hold_gap: assert property (@(posedge ref_clk) disable iff (rst)
    !sample_valid |=> $stable(st_r.mute_gain))
    else $error("mute gain moved between samples");
  a_phone_low_out: assert property (@(posedge ref_clk) disable iff (rst)
    (st_r.stb_d && left_phone_drive_low) ##1 out_valid
    |-> sample_out.left == '0)
    else $error("left phone output not held low");
  a_amp_off_low: assert property (@(posedge ref_clk) disable iff (rst)
    !right_phone_amp_en |-> right_phone_drive_low)
    else $error("right amp off but output not held low");
  a_out_latency: assert property (@(posedge ref_clk) disable iff (rst)
    sample_valid |-> ##2 out_valid
    ##1 (!out_valid || $past(sample_valid, 2)))
    else $error("output strobe not two cycles after sample");
  a_speaker_mono: assert property (@(posedge ref_clk) disable iff (rst)
    (!st_r.cfg.beep.stereo_beep_power && st_r.cfg.beep.mono_beep_power &&
     st_r.cfg.beep.mono_beep_to_speaker && $stable(st_r.cfg.beep))
    |=> speaker_sample == $past(beep_m))
    else $error("mono beep not at unity on speaker");

endmodule : dpv_top
`default_nettype wire

/* verif/dpv_host_model.sv */
// Host sample source: paced sample strobes carrying a held stereo word
`timescale 1ns/1ps
`default_nettype none
module dpv_host_model (
  input wire logic ref_clk, // Core clock
  input wire logic rst, // Sync reset, active high
  input wire dpv_pkg::dpv_stereo_t level, // Word to send each sample
  output logic sample_valid, // One cycle per sample period
  output dpv_pkg::dpv_stereo_t sample_in // Sample word
);
  logic [1:0] div_r;
  // Strobe every fourth cycle; word is inverted between strobes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_r <= 2'h0;
      sample_valid <= 1'b0;
      sample_in <= '0;
    end else begin
      div_r <= div_r + 2'h1;
      sample_valid <= (div_r == 2'h3);
      sample_in <= (div_r == 2'h3) ? level : ~level;
    end
  end
endmodule : dpv_host_model
`default_nettype wire

/* verif/dpv_top_tb_top.sv */
// Testbench: registers, sample path, mute, beep and phone controls
`timescale 1ns/1ps
`default_nettype none
module dpv_top_tb_top;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, sample_valid;
  logic out_valid, tl, tr, tm, sbp, mbp, lb, rb, la, ra, ld, rd_low, err;
  logic [31:0] prdata, pwdata, rd, seed, r;
  logic [7:0] paddr;
  logic signed [15:0] spk;
  dpv_pkg::dpv_stereo_t level, sample_in, sample_out;
  int n_errors, n_compared, cyc;

  dpv_host_model host_u (.ref_clk(ref_clk), .rst(rst), .level(level),
    .sample_valid(sample_valid), .sample_in(sample_in));
  dpv_top dut_u (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .sample_in(sample_in),
    .out_valid(out_valid), .sample_out(sample_out), .speaker_sample(spk),
    .left_tone_input(tl), .right_tone_input(tr), .mono_tone_input(tm),
    .stereo_beep_power(sbp), .mono_beep_power(mbp),
    .left_phone_bias_on(lb), .right_phone_bias_on(rb),
    .left_phone_amp_en(la), .right_phone_amp_en(ra),
    .left_phone_drive_low(ld), .right_phone_drive_low(rd_low));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic signed [15:0] bexp(input logic signed [15:0] x,
                                              input int k);
    if (k == 0) return x;
    if (k == 3) return x + x;
    if (k == 1) return x + (x >>> dpv_pkg::BOOST_MIN_SHIFT);
    return x + (x >>> dpv_pkg::BOOST_MID_SHIFT);
  endfunction : bexp

  task automatic print_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic near(input logic signed [15:0] g, e, input int tol);
    n_compared++;
    if ($isunknown(g) || int'(g) > int'(e) + tol || int'(g) < int'(e) - tol)
    begin
      n_errors++;
      $display("ERROR %0t sample %h near %h", $time, g, e);
    end
  endtask : near

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [15:0] d);
    r = xs();
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {r[31:16], d};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic wait_smp(input int n);
    repeat (n) @(posedge out_valid);
    #1;
  endtask : wait_smp

  task automatic new_level();
    r = xs();
    @(posedge ref_clk);
    level <= r;
  endtask : new_level

  // ****************************************************************
  // Clock, timeout, sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      $display("ERROR %0t timeout", $time);
      print_verdict();
    end
  end

  initial begin
    seed = 32'h0000_001E;
    rst = 1'b1;
    {psel, penable, pwrite, tl, tr, tm} = '0;
    paddr = '0;
    pwdata = '0;
    level = '0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    apb(0, 8'h00, 0); check(rd, 0);
    apb(0, 8'h04, 0); check(rd, 0);
    apb(0, 8'h0C, 0); check(rd, 32'h0000_000C);
    apb(0, 8'h14, 0); check(err, 1); check(rd, 0);
    check({la, ra, ld, rd_low}, 4'h3);
    apb(1, 8'h0C, 16'h0000); check({la, ra, ld, rd_low}, 4'hF);
    apb(1, 8'h0C, 16'h0003); check({lb, rb, ld, rd_low}, 4'hC);
    new_level(); wait_smp(4); near(sample_out.left, level.left, 0);
    for (int k = 0; k < 4; k++) begin
      apb(1, 8'h00, 16'(k));
      level <= {16'h1000, 16'hF000};
      wait_smp(200);
      near(sample_out.left, bexp(16'h1000, k), 20);
      near(sample_out.right, bexp(16'hF000, k), 20);
    end
    level <= {16'h7000, 16'h9000};
    wait_smp(200);
    check({sample_out.left, sample_out.right}, 32'h7FFF_8000);
    apb(1, 8'h00, 16'h0000); new_level();
    apb(1, 8'h04, 16'h00FF); wait_smp(1000);
    apb(0, 8'h10, 0); check(32'(rd[7:0] < 8'hFF), 1);
    wait_smp(70); apb(0, 8'h10, 0); check(rd[7:0], 8'hFF);
    near(sample_out.left, 0, 0);
    apb(1, 8'h04, 16'h0000); wait_smp(1100);
    apb(1, 8'h04, 16'h200C); wait_smp(4);
    apb(0, 8'h10, 0); check(rd[15:0], 16'h0000);
    wait_smp(200); apb(0, 8'h10, 0); check(rd[15:0], 16'h200C);
    near(sample_out.left, level.left >>> 1, 1);
    apb(1, 8'h00, 16'h0004); wait_smp(200);
    apb(0, 8'h10, 0); check(rd[15:0], 16'h0C0C);
    near(sample_out.right, level.right >>> 1, 1);
    apb(1, 8'h00, 16'h0000); apb(1, 8'h04, 16'h0000); wait_smp(200);
    apb(1, 8'h00, 16'h0008); wait_smp(128);
    near(sample_out.left, level.left >>> 1, 600);
    wait_smp(140); near(sample_out.left, 0, 0);
    apb(1, 8'h00, 16'h0000); wait_smp(260);
    near(sample_out.left, level.left, 0);
    apb(1, 8'h00, 16'h0028); wait_smp(64);
    apb(1, 8'h00, 16'h0010); wait_smp(70);
    near(sample_out.right, level.right, 0);
    apb(1, 8'h04, 16'h0C0C);
    apb(1, 8'h00, 16'h0038); wait_smp(1024);
    near(sample_out.left, level.left >>> 2, 600);
    apb(1, 8'h08, 16'h0005); tl <= 1'b1; tr <= 1'b1; repeat (8) @(posedge ref_clk);
    check({sbp, mbp, spk}, 18'h2_2000);
    tr <= 1'b0; repeat (8) @(posedge ref_clk); check(spk, 0);
    apb(1, 8'h08, 16'h0028); repeat (8) @(posedge ref_clk);
    check({sbp, mbp, spk}, 18'h1_E000);
    level <= '0;
    apb(1, 8'h08, 16'h001B); wait_smp(4);
    check(sample_out, 32'h1CCD_DCCD);
    apb(1, 8'h0C, 16'h0000); wait_smp(2);
    check(ld, 1); check(sample_out, 0);
    apb(1, 8'h0C, 16'h000C); check({la, ra, rd_low}, 3'h1);
    print_verdict();
  end
endmodule : dpv_top_tb_top
`default_nettype wire
